//--- shared/tefc_params.svh
// Register indices, field positions, reset values and sizes of the transmit event FIFO controller
`ifndef TEFC_PARAMS_SVH
`define TEFC_PARAMS_SVH
`define TEFC_IDX_CON 2'h0
`define TEFC_IDX_STA 2'h1
`define TEFC_IDX_UA 2'h2
`define TEFC_CON_DEPTH_LSB 24
`define TEFC_CON_DEPTH_MSB 28
`define TEFC_CON_FLUSH 10
`define TEFC_CON_ADVANCE 8
`define TEFC_CON_TSEN 5
`define TEFC_CON_OVIE 3
`define TEFC_CON_FIE 2
`define TEFC_CON_HIE 1
`define TEFC_CON_NEIE 0
`define TEFC_STA_OVF 3
`define TEFC_STA_FULL 2
`define TEFC_STA_HALF 1
`define TEFC_STA_NE 0
`define TEFC_RST_DEPTH 5'h00
`define TEFC_RST_FLUSH 1'h1
`define TEFC_RST_EN 4'h0
`define TEFC_OBJ_BYTES 32'h0000_0008
`define TEFC_STAMP_BYTES 32'h0000_0004
`endif

//--- shared/tefc_pkg.sv
// Types shared by the transmit event FIFO controller
package tefc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] idx;
    logic [31:0] data;
  } tefc_req_s;
  typedef struct packed {
    logic valid;
    logic stamp;
    logic [31:0] addr;
    logic [31:0] stampValue;
  } tefc_ramwr_s;
endpackage

//--- rtl/tefc_event_fifo.sv
// Transmit event FIFO control, status and pointer logic
`timescale 1ns/100ps
`include "tefc_params.svh"
module tefc_event_fifo
  import tefc_pkg::*;
(
  input wire logic clock, // 25 MHz controller clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic configMode, // High while in configuration mode
  input wire tefc_req_s regReq, // Register access, one cycle per strobe
  output tefc_req_s regRsp, // Read data, rd marks valid
  input wire logic eventPush, // Transmit completion event, one-cycle pulse
  input wire logic [31:0] timeStamp, // Time stamp of the completed frame
  input wire logic [31:0] ramBase, // RAM start address of the event FIFO
  output tefc_ramwr_s ramWr, // Event object write to RAM
  output logic eventFifoIrq // Interrupt request, level
);

  logic [4:0] depth_reg;
  logic tsEn_reg;
  logic [3:0] irqEn_reg;
  logic flush_reg;
  logic [4:0] head_reg;
  logic [4:0] tail_reg;
  logic [5:0] count_reg;
  logic ovf_reg;
  tefc_req_s regRsp_reg;
  tefc_ramwr_s ramWr_reg;
  logic irq_reg;

  logic conWr;
  logic staWr;
  logic advance;
  logic pushOk;
  logic popOk;
  logic fullFlag;
  logic halfFlag;
  logic neFlag;
  logic [3:0] flags;
  logic [5:0] depthCnt;
  logic [31:0] rdMux;

  function automatic logic [4:0] nextPtr(input logic [4:0] p, input logic [4:0] last);
    nextPtr = (p == last) ? 5'h00 : 5'(p + 5'h01);
  endfunction

  function automatic logic [31:0] addrOf(input logic [31:0] base, input logic [4:0] p, input logic ts);
    logic [31:0] size;
    size = ts ? 32'(`TEFC_OBJ_BYTES + `TEFC_STAMP_BYTES) : `TEFC_OBJ_BYTES;
    addrOf = 32'(base + 32'(32'(p) * size));
  endfunction

  assign conWr = regReq.wr && (regReq.idx == `TEFC_IDX_CON);
  assign staWr = regReq.wr && (regReq.idx == `TEFC_IDX_STA);
  assign advance = conWr && regReq.data[`TEFC_CON_ADVANCE] && !configMode && !flush_reg;
  assign depthCnt = 6'({1'b0, depth_reg} + 6'h01);
  assign fullFlag = (count_reg == depthCnt);
  assign halfFlag = ({count_reg, 1'b0} >= {1'b0, depthCnt});
  assign neFlag = (count_reg != 6'h00);
  assign flags = {ovf_reg, fullFlag, halfFlag, neFlag};
  assign pushOk = eventPush && !fullFlag && !flush_reg && !configMode;
  assign popOk = advance && neFlag;

  // Depth and time-stamp enable lock outside configuration
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      depth_reg <= `TEFC_RST_DEPTH;
      tsEn_reg <= 1'b0;
    end else if (conWr && configMode) begin
      depth_reg <= regReq.data[`TEFC_CON_DEPTH_MSB:`TEFC_CON_DEPTH_LSB];
      tsEn_reg <= regReq.data[`TEFC_CON_TSEN];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irqEn_reg <= `TEFC_RST_EN;
    end else if (conWr) begin
      irqEn_reg <= {regReq.data[`TEFC_CON_OVIE], regReq.data[`TEFC_CON_FIE],
                    regReq.data[`TEFC_CON_HIE], regReq.data[`TEFC_CON_NEIE]};
    end
  end

  // Flush is held in configuration and completes on the first normal-mode cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flush_reg <= `TEFC_RST_FLUSH;
    end else if (configMode) begin
      flush_reg <= 1'b1;
    end else if (flush_reg) begin
      flush_reg <= 1'b0;
    end else if (conWr && regReq.data[`TEFC_CON_FLUSH]) begin
      flush_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      head_reg <= 5'h00;
      tail_reg <= 5'h00;
      count_reg <= 6'h00;
    end else if (flush_reg) begin
      head_reg <= 5'h00;
      tail_reg <= 5'h00;
      count_reg <= 6'h00;
    end else begin
      if (pushOk) begin
        head_reg <= nextPtr(head_reg, depth_reg);
      end
      if (popOk) begin
        tail_reg <= nextPtr(tail_reg, depth_reg);
      end
      if (pushOk && !popOk) begin
        count_reg <= 6'(count_reg + 6'h01);
      end else if (popOk && !pushOk) begin
        count_reg <= 6'(count_reg - 6'h01);
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ovf_reg <= 1'b0;
    end else if (eventPush && fullFlag && !flush_reg && !configMode) begin
      ovf_reg <= 1'b1;
    end else if (staWr && !regReq.data[`TEFC_STA_OVF]) begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ramWr_reg <= '0;
    end else begin
      ramWr_reg.valid <= pushOk;
      ramWr_reg.stamp <= pushOk && tsEn_reg;
      ramWr_reg.addr <= addrOf(ramBase, head_reg, tsEn_reg);
      ramWr_reg.stampValue <= (pushOk && tsEn_reg) ? timeStamp : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags & irqEn_reg);
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (regReq.idx)
      `TEFC_IDX_CON: begin
        rdMux[`TEFC_CON_DEPTH_MSB:`TEFC_CON_DEPTH_LSB] = depth_reg;
        rdMux[`TEFC_CON_FLUSH] = flush_reg;
        rdMux[`TEFC_CON_TSEN] = tsEn_reg;
        rdMux[`TEFC_CON_OVIE] = irqEn_reg[3];
        rdMux[`TEFC_CON_FIE] = irqEn_reg[2];
        rdMux[`TEFC_CON_HIE] = irqEn_reg[1];
        rdMux[`TEFC_CON_NEIE] = irqEn_reg[0];
      end
      `TEFC_IDX_STA: begin
        rdMux[3:0] = flags;
      end
      `TEFC_IDX_UA: begin
        rdMux = addrOf(ramBase, tail_reg, tsEn_reg);
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regRsp_reg <= '0;
    end else begin
      regRsp_reg.wr <= 1'b0;
      regRsp_reg.rd <= regReq.rd;
      regRsp_reg.idx <= regReq.idx;
      regRsp_reg.data <= regReq.rd ? rdMux : 32'h0000_0000;
    end
  end

  assign regRsp = regRsp_reg;
  assign ramWr = ramWr_reg;
  assign eventFifoIrq = irq_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_depth_locked;
    conWr && !configMode |=> $stable(depth_reg) && $stable(tsEn_reg);
  endproperty
  a_depth_locked: assert property (p_depth_locked) else $error("depth changed outside configuration");

  sequence s_config_held;
    configMode [*2];
  endsequence
  sequence s_flushed;
    !flush_reg && count_reg == 6'h00 && head_reg == 5'h00;
  endsequence
  property p_flush_cycle;
    s_config_held ##1 !configMode |=> s_flushed;
  endproperty
  a_flush_cycle: assert property (p_flush_cycle) else $error("flush did not complete after configuration");

  property p_flush_in_config;
    configMode |=> flush_reg;
  endproperty
  a_flush_in_config: assert property (p_flush_in_config) else $error("flush bit not set in configuration");

  property p_advance;
    popOk && !pushOk && !flush_reg |=>
      tail_reg == nextPtr($past(tail_reg), depth_reg) && count_reg == 6'($past(count_reg) - 6'h01);
  endproperty
  a_advance: assert property (p_advance) else $error("tail did not advance by one");

  property p_stamp;
    pushOk |=> ramWr_reg.valid && ramWr_reg.stamp == $past(tsEn_reg);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp store does not follow enable");

  property p_irq_full;
    fullFlag && irqEn_reg[2] |=> irq_reg;
  endproperty
  a_irq_full: assert property (p_irq_full) else $error("full interrupt missing");

  property p_irq_half;
    halfFlag && irqEn_reg[1] |=> irq_reg;
  endproperty
  a_irq_half: assert property (p_irq_half) else $error("half-full interrupt missing");

  property p_irq_masked;
    (flags & irqEn_reg) == 4'h0 |=> !irq_reg;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised");

  property p_status_read;
    regReq.rd && regReq.idx == `TEFC_IDX_STA |=>
      regRsp_reg.data[2] == ($past(count_reg) == $past(depthCnt)) &&
      regRsp_reg.data[0] == ($past(count_reg) != 6'h00) && regRsp_reg.data[31:4] == 28'h0000000;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_half;
    halfFlag == (count_reg >= 6'(({1'b0, depth_reg} + 6'h02) >> 1));
  endproperty
  a_half: assert property (p_half) else $error("half flag mismatch");

  property p_ua_read;
    regReq.rd && regReq.idx == `TEFC_IDX_UA |=>
      regRsp_reg.data == addrOf($past(ramBase), $past(tail_reg), $past(tsEn_reg));
  endproperty
  a_ua_read: assert property (p_ua_read) else $error("address read mismatch");

  property p_overflow;
    eventPush && fullFlag && !flush_reg && !configMode |=> ovf_reg && $stable(count_reg);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

endmodule

//--- verification/tefc_host_model.sv
// Host model making register accesses to the event FIFO controller
`timescale 1ns/100ps
module tefc_host_model
  import tefc_pkg::*;
(
  input wire logic clock, // Controller clock
  output tefc_req_s regReq, // Register access request
  input wire tefc_req_s regRsp // Registered read response
);
  initial regReq = '0;
  // Request held across one rising edge, response taken one cycle later
  task automatic access(input logic wr, input logic [1:0] idx, input logic [31:0] data, output logic [31:0] rdata);
    @(negedge clock);
    regReq = '{wr: wr, rd: !wr, idx: idx, data: data};
    @(negedge clock);
    rdata = regRsp.data;
    regReq = '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: ~data};
  endtask
endmodule

//--- verification/tefc_event_fifo_tb.sv
// Self-checking testbench of the event FIFO controller
`timescale 1ns/100ps
`include "tefc_params.svh"
module tefc_event_fifo_tb
  import tefc_pkg::*;
;
  localparam logic [31:0] BASE = 32'h0000_0400;
  typedef struct packed {logic [31:0] ts; logic [31:0] addr; logic [31:0] sta;} tefc_row_s;
  logic clock = 1'b0;
  logic arstN = 1'b0;
  logic configMode = 1'b1;
  logic eventPush = 1'b0;
  logic [31:0] timeStamp = 32'h0;
  tefc_req_s regReq;
  tefc_req_s regRsp;
  tefc_ramwr_s ramWr;
  logic eventFifoIrq;
  logic [31:0] rd;
  int bad_count = 0;
  int checked = 0;
  tefc_row_s rows [4] = '{'{32'hA5A5_0001, 32'h0000_0400, 32'h1}, '{32'hA5A5_0002, 32'h0000_040C, 32'h3},
    '{32'hA5A5_0003, 32'h0000_0418, 32'h3}, '{32'hA5A5_0004, 32'h0000_0424, 32'h7}};
  // Enables in the upper nibble, expected interrupt level in bit 0
  logic [7:0] masks [5] = '{8'h00, 8'h21, 8'h40, 8'h11, 8'h80};
  always #20 clock = ~clock;
  tefc_event_fifo i_dut (.clock(clock), .arst_n(arstN), .configMode(configMode), .regReq(regReq),
    .regRsp(regRsp), .eventPush(eventPush), .timeStamp(timeStamp), .ramBase(BASE), .ramWr(ramWr),
    .eventFifoIrq(eventFifoIrq));
  tefc_host_model i_host (.clock(clock), .regReq(regReq), .regRsp(regRsp));
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask
  task automatic rdReg(input logic [1:0] idx, input logic [31:0] exp);
    i_host.access(1'b0, idx, 32'h0, rd);
    chk(exp, rd);
    // Response qualifiers still stand until the next rising edge
    chk({28'h0, 2'b01, idx}, {28'h0, regRsp.wr, regRsp.rd, regRsp.idx});
  endtask
  task automatic wrReg(input logic [1:0] idx, input logic [31:0] data);
    i_host.access(1'b1, idx, data, rd);
  endtask
  task automatic push(input logic [31:0] ts);
    @(negedge clock);
    eventPush = 1'b1;
    timeStamp = ts;
    @(negedge clock);
    eventPush = 1'b0;
    timeStamp = ~ts;
  endtask
  task automatic results();
    $display("counts: checked %0d, bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    results();
  end
  initial begin
    repeat (10) @(negedge clock);
    arstN = 1'b1;
    rdReg(`TEFC_IDX_CON, 32'h0000_0400);
    rdReg(`TEFC_IDX_STA, 32'h0000_0000);
    wrReg(`TEFC_IDX_CON, 32'hE3FF_F3FF);
    rdReg(`TEFC_IDX_CON, 32'h0300_042F);
    configMode = 1'b0;
    repeat (2) @(negedge clock);
    rdReg(`TEFC_IDX_CON, 32'h0300_002F);
    wrReg(`TEFC_IDX_CON, 32'h0000_000F);
    rdReg(`TEFC_IDX_CON, 32'h0300_002F);
    rdReg(`TEFC_IDX_UA, BASE);
    $display("test reset and configuration done");
    foreach (rows[i]) begin
      push(rows[i].ts);
      chk(32'h3, {30'h0, ramWr.valid, ramWr.stamp});
      chk(rows[i].addr, ramWr.addr);
      chk(rows[i].ts, ramWr.stampValue);
      rdReg(`TEFC_IDX_STA, rows[i].sta);
      chk(32'h1, {31'h0, eventFifoIrq});
    end
    $display("test fill done");
    push(32'h0BAD_0BAD);
    chk(32'h0, {31'h0, ramWr.valid});
    rdReg(`TEFC_IDX_STA, 32'h0000_000F);
    wrReg(`TEFC_IDX_STA, 32'hFFFF_FFF0);
    rdReg(`TEFC_IDX_STA, 32'h0000_0007);
    rdReg(`TEFC_IDX_UA, BASE);
    wrReg(`TEFC_IDX_CON, 32'h0000_012F);
    rdReg(`TEFC_IDX_UA, BASE + 32'h0000_000C);
    rdReg(`TEFC_IDX_CON, 32'h0300_002F);
    rdReg(`TEFC_IDX_STA, 32'h0000_0003);
    rdReg(2'h3, 32'h0000_0000);
    $display("test overflow and advance done");
    foreach (masks[i]) begin
      wrReg(`TEFC_IDX_CON, {28'h0, masks[i][7:4]});
      repeat (2) @(negedge clock);
      chk({31'h0, masks[i][0]}, {31'h0, eventFifoIrq});
    end
    $display("test interrupt masking done");
    configMode = 1'b1;
    repeat (2) @(negedge clock);
    wrReg(`TEFC_IDX_CON, 32'h0300_0000);
    rdReg(`TEFC_IDX_CON, 32'h0300_0400);
    configMode = 1'b0;
    repeat (2) @(negedge clock);
    push(32'h1234_5678);
    chk(32'h2, {30'h0, ramWr.valid, ramWr.stamp});
    chk(BASE, ramWr.addr);
    chk(32'h0, ramWr.stampValue);
    $display("test flush and unstamped event done");
    wrReg(`TEFC_IDX_CON, 32'h0000_0400);
    rdReg(`TEFC_IDX_STA, 32'h0000_0000);
    rdReg(`TEFC_IDX_CON, 32'h0300_0000);
    rdReg(`TEFC_IDX_UA, BASE);
    wrReg(`TEFC_IDX_CON, 32'h0000_0008);
    repeat (4) push(32'h0000_0000);
    repeat (2) @(negedge clock);
    chk(32'h0, {31'h0, eventFifoIrq});
    push(32'h0000_0000);
    repeat (2) @(negedge clock);
    chk(32'h1, {31'h0, eventFifoIrq});
    rdReg(`TEFC_IDX_STA, 32'h0000_000F);
    wrReg(`TEFC_IDX_CON, 32'h0000_0004);
    repeat (2) @(negedge clock);
    chk(32'h1, {31'h0, eventFifoIrq});
    // Flush empties the FIFO but leaves the overflow flag for software
    wrReg(`TEFC_IDX_CON, 32'h0000_0400);
    rdReg(`TEFC_IDX_STA, 32'h0000_0008);
    $display("test software flush and overflow interrupt done");
    results();
  end
endmodule
